// *** design/trace_id_access_check.sv ***
// access checker: decides return, undefined or trap for an id register read
// assumes: level and trap controls are stable in the request cycle; purely combinational
`timescale 1ns/100ps
`default_nettype none
module trace_id_access_check
    import trace_id_pkg::*;
(
    input wire trace_id_pkg::exc_level_e level,
    input wire trace_id_pkg::trap_ctrl_s ctrl,
    output logic [2:0] outcome,
    output logic [1:0] target_level
);
    wire halted_no_debug = ctrl.halted && ctrl.secure_debug_disabled;
    wire top_trap = ctrl.third_level_trap;
    wire hyp_trap = ctrl.second_level_enabled && ctrl.second_level_trap;
    wire fgt_trap = ctrl.second_level_enabled && ctrl.fine_grained_trap_enable && ctrl.trace_id_read_trap_bit;

    always_comb
    begin
        outcome = outcome_return;
        target_level = level;
        case (level)
            el_user:
            begin
                outcome = outcome_undef; // [R11]
            end
            el_kernel:
            begin
                if (halted_no_debug && top_trap)
                begin
                    outcome = outcome_undef; // [R12]
                end
                else if (ctrl.first_level_trap)
                begin
                    outcome = outcome_trap; // [R13]
                    target_level = el_kernel;
                end
                else if (hyp_trap)
                begin
                    outcome = outcome_trap; // [R14]
                    target_level = el_hyp;
                end
                else if (fgt_trap)
                begin
                    outcome = outcome_trap; // [R15]
                    target_level = el_hyp;
                end
                else if (top_trap)
                begin
                    outcome = outcome_trap; // [R16]
                    target_level = el_monitor;
                end
            end
            el_hyp:
            begin
                // second level traps itself regardless of its enable
                if (halted_no_debug && top_trap)
                begin
                    outcome = outcome_undef; // [R12]
                end
                else if (ctrl.second_level_trap)
                begin
                    outcome = outcome_trap; // [R17]
                    target_level = el_hyp;
                end
                else if (top_trap)
                begin
                    outcome = outcome_trap; // [R16]
                    target_level = el_monitor;
                end
            end
            el_monitor:
            begin
                if (top_trap)
                begin
                    outcome = outcome_trap; // [R18]
                    target_level = el_monitor;
                end
            end
            default:
            begin
                outcome = outcome_undef;
            end
        endcase
    end
endmodule : trace_id_access_check
`default_nettype wire

// *** design/trace_id_pkg.sv ***
// package: encodings, field layouts and access-check codes for the trace id register block
// assumes: shared by the access checker and the register read port
package trace_id_pkg;

    // system register encoding (op0, op1, crn, crm, op2) of each id register
    localparam logic [1:0] sysreg_op0 = 2'h2;
    localparam logic [2:0] sysreg_op1 = 3'h1;
    localparam logic [3:0] sysreg_crn = 4'h0;
    localparam logic [3:0] crm_id_one = 4'h9;
    localparam logic [3:0] crm_id_two = 4'ha;
    localparam logic [2:0] sysreg_op2 = 3'h7;

    // id one field positions
    localparam int designer_lsb = 24;
    localparam int res1_lsb = 12;
    localparam int arch_major_lsb = 8;
    localparam int arch_minor_lsb = 4;
    localparam int revision_lsb = 0;

    // id one field values
    localparam logic [7:0] designer_code_default = 8'h5a; // arbitrary neutral value
    localparam logic [3:0] res1_nibble = 4'hf;
    localparam logic [3:0] arch_major_version = 4'hf;
    localparam logic [3:0] arch_minor_version = 4'hf;
    localparam logic [3:0] revision_default = 4'h0;

    // id two field positions
    localparam int wait_instr_class_lsb = 31;
    localparam int virtual_context_option_lsb = 29;
    localparam int cycle_counter_size_lsb = 25;
    localparam int virtual_context_id_size_lsb = 10;
    localparam int context_id_size_lsb = 5;
    localparam int instruction_address_size_lsb = 0;

    // id two field values
    localparam logic [0:0] wait_instr_class_flag = 1'h1;
    localparam logic [1:0] virtual_context_option = 2'h2;
    localparam logic [3:0] cycle_counter_size = 4'h0;
    localparam logic [4:0] virtual_context_id_size = 5'h04;
    localparam logic [4:0] context_id_size = 5'h04;
    localparam logic [4:0] instruction_address_size = 5'h08;

    localparam logic [5:0] syndrome_class_trace = 6'h18;

    typedef enum logic [1:0]
    {
        el_user = 2'h0,
        el_kernel = 2'h1,
        el_hyp = 2'h2,
        el_monitor = 2'h3
    } exc_level_e;

    // outcome of one read; one-hot codes
    typedef enum logic [2:0]
    {
        outcome_return = 3'h1,
        outcome_undef = 3'h2,
        outcome_trap = 3'h4
    } outcome_e;

    // trap controls that the rest of the core owns
    typedef struct packed
    {
        logic halted;
        logic secure_debug_disabled;
        logic first_level_trap;
        logic second_level_enabled;
        logic second_level_trap;
        logic third_level_trap;
        logic fine_grained_trap_enable;
        logic trace_id_read_trap_bit;
    } trap_ctrl_s;

    typedef struct packed
    {
        logic valid;
        exc_level_e level;
        logic [1:0] op0;
        logic [2:0] op1;
        logic [3:0] crn;
        logic [3:0] crm;
        logic [2:0] op2;
    } read_req_s;

    typedef struct packed
    {
        logic valid;
        logic hit;
        outcome_e outcome;
        exc_level_e target_level;
        logic [5:0] syndrome_class;
        logic [63:0] data;
    } read_rsp_s;

endpackage : trace_id_pkg

// *** design/trace_id_registers.sv ***
// trace unit identification registers one and two, read by system register instructions
// assumes: one request per cycle on req; answer registered one cycle later on rsp
//
// Functional notes
// R1 - id one bits 31:24 hold the designer code, encoded like the main id implementer
// R2 - major and minor version both all ones; software then uses device architecture register
// R3 - revision bits 3:0 are deprecated; software must not rely on them
// R4 - id two bit 31 reads one: wait instructions count as P0
// R5 - virtual context option bits 30:29 read 0b10, selection unsupported
// R6 - cycle counter size bits 28:25 read zero, a 12-bit counter
// R7 - virtual context id size bits 14:10 encode 32 bits
// R8 - context id size bits 9:5 encode 32 bits
// R9 - instruction address size bits 4:0 encode 64 bits
// R10 - low 32 bits match the externally accessible copy of each register
// R11 - read from the least privileged level is undefined
// R12 - at levels one or two: halted, secure debug disabled, top trap set gives undefined
// R13 - level one with first-level trace trap set traps to level one, class 0x18
// R14 - level one with level two enabled and its trap set traps to level two
// R15 - level one fine-grained trace id read trap traps to level two
// R16 - top trap set otherwise traps to level three, or undefined when halted without debug
// R17 - level two with its trace trap set traps to level two, class 0x18
// R18 - level three traps to itself on its trap bit, else returns the value
// R19 - every field is a constant, untouched by reset or software
`timescale 1ns/100ps
`default_nettype none
module trace_id_registers
    import trace_id_pkg::*;
#(
    parameter logic [7:0] designer_code = designer_code_default, // arbitrary neutral value
    parameter logic [3:0] revision = revision_default
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire trace_id_pkg::read_req_s req,
    input wire trace_id_pkg::trap_ctrl_s ctrl,
    output trace_id_pkg::read_rsp_s rsp,
    output logic [31:0] ext_id_one,
    output logic [31:0] ext_id_two
);
    import trace_id_pkg::*;

    // fixed values; no reset, no write path [R19]
    wire [31:0] id_one_low = (32'(designer_code) << designer_lsb) // [R1]
        | (32'(res1_nibble) << res1_lsb)
        | (32'(arch_major_version) << arch_major_lsb) // [R2]
        | (32'(arch_minor_version) << arch_minor_lsb) // [R2]
        | (32'(revision) << revision_lsb); // [R3]
    wire [31:0] id_two_low = (32'(wait_instr_class_flag) << wait_instr_class_lsb) // [R4]
        | (32'(virtual_context_option) << virtual_context_option_lsb) // [R5]
        | (32'(cycle_counter_size) << cycle_counter_size_lsb) // [R6]
        | (32'(virtual_context_id_size) << virtual_context_id_size_lsb) // [R7]
        | (32'(context_id_size) << context_id_size_lsb) // [R8]
        | (32'(instruction_address_size) << instruction_address_size_lsb); // [R9]

    // the external copy shares the very same wires, so the two views cannot drift
    assign ext_id_one = id_one_low; // [R10]
    assign ext_id_two = id_two_low; // [R10]

    wire enc_common = (req.op0 == sysreg_op0) && (req.op1 == sysreg_op1)
        && (req.crn == sysreg_crn) && (req.op2 == sysreg_op2);
    wire sel_one = enc_common && (req.crm == crm_id_one);
    wire sel_two = enc_common && (req.crm == crm_id_two);
    wire hit = req.valid && (sel_one || sel_two);

    logic [2:0] chk_outcome;
    logic [1:0] chk_level;

    trace_id_access_check u_check
    (
        .level(req.level),
        .ctrl(ctrl),
        .outcome(chk_outcome),
        .target_level(chk_level)
    );

    wire is_return = (chk_outcome == outcome_return);
    wire is_trap = (chk_outcome == outcome_trap);
    wire [31:0] sel_data = sel_one ? id_one_low : id_two_low;
    // upper word reserved, reads zero; data shown only when the read is allowed [R18]
    wire [63:0] next_data = (hit && is_return) ? {32'h0, sel_data} : 64'h0;
    wire [5:0] next_class = (hit && is_trap) ? syndrome_class_trace : 6'h00; // [R13] [R17]

    read_rsp_s next_rsp;
    always_comb
    begin
        next_rsp.valid = req.valid;
        next_rsp.hit = hit;
        next_rsp.outcome = hit ? outcome_e'(chk_outcome) : outcome_return;
        next_rsp.target_level = exc_level_e'(hit ? chk_level : req.level);
        next_rsp.syndrome_class = next_class;
        next_rsp.data = next_data;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rsp <= '{valid: 1'b0, hit: 1'b0, outcome: outcome_return, target_level: el_user,
                     syndrome_class: 6'h00, data: 64'h0};
        end
        else
        begin
            rsp <= next_rsp;
        end
    end
endmodule : trace_id_registers
`default_nettype wire

// *** test/trace_id_props.sv ***
// checker: value and timing relations at the trace id register ports
// assumes: bound to trace_id_registers from the bench top file
`timescale 1ns/100ps
`default_nettype none
module trace_id_props
    import trace_id_pkg::*;
#(
    parameter logic [7:0] designer_code = designer_code_default,
    parameter logic [3:0] revision = revision_default
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire trace_id_pkg::read_req_s req,
    input wire trace_id_pkg::trap_ctrl_s ctrl,
    input wire trace_id_pkg::read_rsp_s rsp,
    input wire logic [31:0] ext_id_one,
    input wire logic [31:0] ext_id_two
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire logic id_hit = req.valid && req.op0 == sysreg_op0 && req.op1 == sysreg_op1 && req.crn == sysreg_crn
        && req.op2 == sysreg_op2 && (req.crm == crm_id_one || req.crm == crm_id_two);
    // halted with secure debug off and the top trap set beats every trap below level three
    wire logic lock = ctrl.halted && ctrl.secure_debug_disabled && ctrl.third_level_trap;
    property p_ext_one;
        ext_id_one == {designer_code, 8'h00, 4'hf, 4'hf, 4'hf, revision};
    endproperty
    a_ext_one: assert property (p_ext_one) else $error("id one copy wrong");
    property p_ext_two;
        ext_id_two == 32'hc0001088;
    endproperty
    a_ext_two: assert property (p_ext_two) else $error("id two copy wrong");
    property p_answer;
        1'b1 |=> rsp.valid == $past(req.valid);
    endproperty
    a_answer: assert property (p_answer) else $error("answer not one cycle after request");
    property p_user;
        id_hit && req.level == el_user |=> rsp.outcome == outcome_undef;
    endproperty
    a_user: assert property (p_user) else $error("user level read not undefined");
    property p_lock;
        id_hit && (req.level == el_kernel || req.level == el_hyp) && lock |=> rsp.outcome == outcome_undef;
    endproperty
    a_lock: assert property (p_lock) else $error("halted read not undefined");
    property p_first;
        id_hit && req.level == el_kernel && !lock && ctrl.first_level_trap
        |=> rsp.outcome == outcome_trap && rsp.target_level == el_kernel && rsp.syndrome_class == 6'h18;
    endproperty
    a_first: assert property (p_first) else $error("level one trap wrong");
    property p_second;
        id_hit && req.level == el_hyp && !lock && ctrl.second_level_trap
        |=> rsp.outcome == outcome_trap && rsp.target_level == el_hyp;
    endproperty
    a_second: assert property (p_second) else $error("level two trap wrong");
    property p_top;
        id_hit && req.level == el_monitor
        |=> rsp.outcome == ($past(ctrl.third_level_trap) ? outcome_trap : outcome_return);
    endproperty
    a_top: assert property (p_top) else $error("level three outcome wrong");
    property p_data;
        rsp.valid && rsp.hit && rsp.outcome == outcome_return
        |-> rsp.data == {32'h0, $past(req.crm) == crm_id_one ? ext_id_one : ext_id_two};
    endproperty
    a_data: assert property (p_data) else $error("read data differs from copy");
endmodule : trace_id_props
`default_nettype wire

// *** test/pe_reader.sv ***
// partner: processing element issuing id register reads one at a time
// assumes: trap controls are levels held between reads
`timescale 1ns/100ps
`default_nettype none
module pe_reader
    import trace_id_pkg::*;
(
    input wire logic clk_sys,
    input wire trace_id_pkg::read_rsp_s rsp,
    output trace_id_pkg::read_req_s req,
    output trace_id_pkg::trap_ctrl_s ctrl
);
    initial
    begin
        req = '0;
        ctrl = '0;
    end
    task automatic read(input read_req_s r, input trap_ctrl_s c, output read_rsp_s q);
        @(posedge clk_sys);
        req <= r;
        ctrl <= c;
        @(posedge clk_sys);
        // released encoding turns over so a stale request never looks held
        req <= read_req_s'(~r);
        #1;
        q = rsp;
    endtask : read
endmodule : pe_reader
`default_nettype wire

// *** test/tb.sv ***
// bench: sweeps every level and trap setting over both id registers
// assumes: pe_reader issues reads; trace_id_props bound at the foot
`timescale 1ns/100ps
`default_nettype none
module tb;
    import trace_id_pkg::*;
    localparam logic [31:0] id_one = {designer_code_default, 8'h00, 4'hf, 4'hf, 4'hf, 4'h0};
    localparam logic [31:0] id_two = {1'b1, 2'b10, 4'h0, 10'h0, 5'h04, 5'h04, 5'h08};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    read_req_s req;
    trap_ctrl_s ctrl;
    read_rsp_s rsp;
    read_rsp_s q;
    read_req_s r;
    trap_ctrl_s c;
    logic [31:0] ext_id_one;
    logic [31:0] ext_id_two;
    logic [63:0] mask;
    logic [12:0] exp_head;
    logic [63:0] exp_data;
    logic [2:0] exp_out;
    logic [1:0] exp_tgt;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    trace_id_registers uut(.clk_sys(clk_sys), .rst(rst), .req(req), .ctrl(ctrl), .rsp(rsp),
        .ext_id_one(ext_id_one), .ext_id_two(ext_id_two));
    pe_reader pe(.clk_sys(clk_sys), .rsp(rsp), .req(req), .ctrl(ctrl));
    initial
    begin
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            results();
        end
    end
    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        if (fail_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results
    task automatic expect_access(input logic [1:0] lv, input trap_ctrl_s k);
        exp_tgt = lv;
        exp_out = outcome_trap;
        if (lv == 2'h0 || (lv != 2'h3 && k.halted && k.secure_debug_disabled && k.third_level_trap))
            exp_out = outcome_undef;
        else if (lv == 2'h1 && k.first_level_trap)
            exp_tgt = 2'h1;
        else if (lv == 2'h1 && k.second_level_enabled && (k.second_level_trap || (k.fine_grained_trap_enable
            && k.trace_id_read_trap_bit)))
            exp_tgt = 2'h2;
        else if (lv == 2'h2 && k.second_level_trap)
            exp_tgt = 2'h2;
        else if (k.third_level_trap)
            exp_tgt = 2'h3;
        else
            exp_out = outcome_return;
    endtask : expect_access
    initial
    begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        check(80'({rsp.valid, rsp.outcome, rsp.data}), 80'({1'b0, 3'h1, 64'h0}));
        check(80'({ext_id_one[31:4], ext_id_two}), 80'({id_one[31:4], id_two}));
        for (int lv = 0; lv < 4; lv++)
            for (int k = 0; k < 256; k++)
                for (int m = 0; m < 2; m++)
                begin
                    r = '{1'b1, exc_level_e'(lv), sysreg_op0, sysreg_op1, sysreg_crn,
                        m ? crm_id_two : crm_id_one, sysreg_op2};
                    c = 8'(k);
                    expect_access(2'(lv), c);
                    // revision nibble is deprecated, so it is never relied on
                    mask = m ? 64'h0 : 64'hf;
                    exp_head = {2'h3, exp_out, exp_tgt, exp_out == outcome_trap ? 6'h18 : 6'h0};
                    exp_data = exp_out == outcome_return ? {32'h0, m ? id_two : id_one} : 64'h0;
                    pe.read(r, c, q);
                    check(80'({q.valid, q.hit, q.outcome, q.target_level, q.syndrome_class}), 80'(exp_head));
                    check(80'(q.data & ~mask), 80'(exp_data & ~mask));
                end
        r.crm = 4'hb;
        pe.read(r, '0, q);
        check(80'({q.valid, q.hit, q.outcome, q.data}), 80'({2'h2, 3'h1, 64'h0}));
        @(posedge clk_sys);
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        r.crm = crm_id_two;
        pe.read(r, '0, q);
        check(80'(q.data), 80'({32'h0, id_two}));
        results();
    end
endmodule : tb
bind trace_id_registers trace_id_props #(.designer_code(designer_code), .revision(revision)) props(.clk_sys(clk_sys),
    .rst(rst), .req(req), .ctrl(ctrl), .rsp(rsp), .ext_id_one(ext_id_one), .ext_id_two(ext_id_two));
`default_nettype wire
